/* design/sbsf_top.sv */
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module sbsf_top
(
   input  wire logic                          i_ref_clk,
   input  wire logic                          i_nrst,
   input  wire logic [sbsf_pkg::ADDR_W-1:0]   i_awaddr,
   input  wire logic                          i_awvalid,
   output logic                               o_awready,
   input  wire logic [sbsf_pkg::DATA_W-1:0]   i_wdata,
   input  wire logic [3:0]                    i_wstrb,
   input  wire logic                          i_wvalid,
   output logic                               o_wready,
   output logic [1:0]                         o_bresp,
   output logic                               o_bvalid,
   input  wire logic                          i_bready,
   input  wire logic [sbsf_pkg::ADDR_W-1:0]   i_araddr,
   input  wire logic                          i_arvalid,
   output logic                               o_arready,
   output logic [sbsf_pkg::DATA_W-1:0]        o_rdata,
   output logic [1:0]                         o_rresp,
   output logic                               o_rvalid,
   input  wire logic                          i_rready,
   output logic [sbsf_pkg::WORD_W-1:0]        o_tx_word,
   output logic                               o_tx_valid,
   input  wire logic                          i_tx_take,
   input  wire logic [sbsf_pkg::WORD_W-1:0]   i_rx_word,
   input  wire logic                          i_rx_load,
   output logic                               o_tx_buffer_full_flag,
   output logic                               o_rx_buffer_full_flag,
   output logic                               o_irq
);
   // ---------------------------------------------
   // Declarations
   // ---------------------------------------------
   sbsf_mem_if tx_mem ();  // Transmit holding store
   sbsf_mem_if rx_mem ();  // Receive holding store

   // Write channel state
   logic                         aw_hold_reg, aw_hold_next;  // Address held
   logic [sbsf_pkg::ADDR_W-1:0]  aw_addr_reg, aw_addr_next;
   logic                         w_hold_reg, w_hold_next;    // Data held
   logic [sbsf_pkg::DATA_W-1:0]  w_data_reg, w_data_next;
   logic [3:0]                   w_strb_reg, w_strb_next;
   logic                         awready_reg, awready_next;
   logic                         wready_reg, wready_next;
   logic                         bvalid_reg, bvalid_next;
   logic [1:0]                   bresp_reg, bresp_next;
   logic                         wr_exec;                    // Write performed
   logic [sbsf_pkg::ADDR_W-1:0]  wr_off;                     // Word-aligned byte offset

   // Read channel state
   sbsf_pkg::sbsf_rd_e           rd_state_reg, rd_state_next;
   logic [sbsf_pkg::ADDR_W-1:0]  ar_addr_reg, ar_addr_next;
   logic                         arready_reg, arready_next;
   logic [sbsf_pkg::DATA_W-1:0]  rdata_reg, rdata_next;
   logic [1:0]                   rresp_reg, rresp_next;
   logic                         rvalid_reg, rvalid_next;
   logic [sbsf_pkg::ADDR_W-1:0]  rd_off;

   // Buffer state
   logic                         enh_reg, enh_next;          // Enhanced mode
   logic [sbsf_pkg::CNT_W-1:0]   cap;                        // Capacity of the current mode
   logic [sbsf_pkg::CNT_W-1:0]   tx_cnt_reg, tx_cnt_next;
   logic [sbsf_pkg::PTR_W-1:0]   tx_wp_reg, tx_wp_next;
   logic [sbsf_pkg::PTR_W-1:0]   tx_rp_reg, tx_rp_next;
   logic                         tx_full_reg, tx_full_next;
   logic                         tx_valid_reg, tx_valid_next;
   logic [sbsf_pkg::CNT_W-1:0]   rx_cnt_reg, rx_cnt_next;
   logic [sbsf_pkg::PTR_W-1:0]   rx_wp_reg, rx_wp_next;
   logic [sbsf_pkg::PTR_W-1:0]   rx_rp_reg, rx_rp_next;
   logic                         rx_full_reg, rx_full_next;
   logic                         rx_stale_reg, rx_stale_next; // Read word not settled
   logic                         tx_push, tx_pop, tx_refuse;
   logic                         rx_push, rx_pop, rx_drop;
   logic [sbsf_pkg::WORD_W-1:0]  wr_word;                    // Lane-merged word

   // Interrupt state
   logic [sbsf_pkg::IRQ_W-1:0]   irq_stat_reg, irq_stat_next;
   logic [sbsf_pkg::IRQ_W-1:0]   irq_mask_reg, irq_mask_next;
   logic [sbsf_pkg::IRQ_W-1:0]   irq_set, irq_clr;
   logic                         irq_reg, irq_next;

   // ---------------------------------------------
   // Write channel
   // ---------------------------------------------
   // Address and data taken in either order, applied once both held
   always_comb
   begin
      aw_hold_next = aw_hold_reg;
      aw_addr_next = aw_addr_reg;
      w_hold_next  = w_hold_reg;
      w_data_next  = w_data_reg;
      w_strb_next  = w_strb_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      wr_exec      = aw_hold_reg && w_hold_reg && !bvalid_reg;
      wr_off       = {aw_addr_reg[sbsf_pkg::ADDR_W-1:2], 2'h0};
      if (i_awvalid && awready_reg)
      begin
         aw_hold_next = 1'b1;
         aw_addr_next = i_awaddr;
      end
      if (i_wvalid && wready_reg)
      begin
         w_hold_next = 1'b1;
         w_data_next = i_wdata;
         w_strb_next = i_wstrb;
      end
      if (wr_exec)
      begin
         aw_hold_next = 1'b0;
         w_hold_next  = 1'b0;
         bvalid_next  = 1'b1;
         // Unmapped offsets answer with an error, nothing stored
         if (wr_off == sbsf_pkg::OFF_BUF || wr_off == sbsf_pkg::OFF_STAT ||
             wr_off == sbsf_pkg::OFF_IRQ_STAT || wr_off == sbsf_pkg::OFF_IRQ_MASK)
         begin
            bresp_next = sbsf_pkg::RESP_OKAY;
         end
         else
         begin
            bresp_next = sbsf_pkg::RESP_SLVERR;
         end
      end
      else if (bvalid_reg && i_bready)
      begin
         bvalid_next = 1'b0;
      end
      // Each channel refuses more until its held item is used and the response is taken
      awready_next = !aw_hold_next && !bvalid_next;
      wready_next  = !w_hold_next && !bvalid_next;
   end

   // ---------------------------------------------
   // Read channel
   // ---------------------------------------------
   // One wait cycle lets the registered store output settle
   always_comb
   begin
      rd_state_next = rd_state_reg;
      ar_addr_next  = ar_addr_reg;
      rdata_next    = rdata_reg;
      rresp_next    = rresp_reg;
      rd_off        = {ar_addr_reg[sbsf_pkg::ADDR_W-1:2], 2'h0};
      rx_pop        = 1'b0;
      case (rd_state_reg)
         sbsf_pkg::RD_IDLE:
         begin
            if (i_arvalid && arready_reg)
            begin
               ar_addr_next  = i_araddr;
               rd_state_next = sbsf_pkg::RD_WAIT;
            end
         end
         sbsf_pkg::RD_WAIT:
         begin
            // Hold off while a word just landed in an empty store
            if (!rx_stale_reg)
            begin
               rd_state_next = sbsf_pkg::RD_RESP;
               rdata_next    = '0;
               rresp_next    = sbsf_pkg::RESP_OKAY;
               case (rd_off)
                  sbsf_pkg::OFF_BUF:
                  begin
                     // Reading an empty buffer returns zero
                     if (rx_cnt_reg != sbsf_pkg::CNT_ZERO)
                     begin
                        rdata_next[sbsf_pkg::WORD_W-1:0] = rx_mem.rdata;
                        rx_pop = 1'b1;
                     end
                  end
                  sbsf_pkg::OFF_STAT:
                  begin
                     rdata_next[sbsf_pkg::STAT_RXF_BIT] = rx_full_reg;
                     rdata_next[sbsf_pkg::STAT_TXF_BIT] = tx_full_reg;
                     rdata_next[sbsf_pkg::STAT_ENH_BIT] = enh_reg;
                  end
                  sbsf_pkg::OFF_IRQ_STAT:
                  begin
                     rdata_next[sbsf_pkg::IRQ_W-1:0] = irq_stat_reg;
                  end
                  sbsf_pkg::OFF_IRQ_MASK:
                  begin
                     rdata_next[sbsf_pkg::IRQ_W-1:0] = irq_mask_reg;
                  end
                  default:
                  begin
                     rresp_next = sbsf_pkg::RESP_SLVERR;
                  end
               endcase
            end
         end
         sbsf_pkg::RD_RESP:
         begin
            if (i_rready)
            begin
               rd_state_next = sbsf_pkg::RD_IDLE;
            end
         end
         default:
         begin
            rd_state_next = sbsf_pkg::RD_IDLE;
         end
      endcase
      arready_next = (rd_state_next == sbsf_pkg::RD_IDLE);
      rvalid_next  = (rd_state_next == sbsf_pkg::RD_RESP);
   end

   // ---------------------------------------------
   // Buffers and flags
   // ---------------------------------------------
   // Flags follow occupancy against the mode's capacity
   always_comb
   begin
      // Byte lanes gated by the held strobes, not the live bus ones
      wr_word = {w_strb_reg[1] ? w_data_reg[15:8] : 8'h00,
                 w_strb_reg[0] ? w_data_reg[7:0] : 8'h00};
      enh_next = enh_reg;
      if (wr_exec && wr_off == sbsf_pkg::OFF_STAT && w_strb_reg[0])
      begin
         enh_next = w_data_reg[sbsf_pkg::STAT_ENH_BIT];
      end
      cap = enh_reg ? sbsf_pkg::CAP_ENH : sbsf_pkg::CAP_STD;
      // A write to a full transmit side is refused
      tx_push   = wr_exec && wr_off == sbsf_pkg::OFF_BUF && (|w_strb_reg[1:0])
                  && !tx_full_reg;
      tx_refuse = wr_exec && wr_off == sbsf_pkg::OFF_BUF && (|w_strb_reg[1:0])
                  && tx_full_reg;
      tx_pop    = tx_valid_reg && i_tx_take;
      // A word from the shifter is lost while the receive side is full
      rx_push   = i_rx_load && !rx_full_reg;
      rx_drop   = i_rx_load && rx_full_reg;
      tx_cnt_next = tx_cnt_reg;
      if (tx_push && !tx_pop)
      begin
         tx_cnt_next = tx_cnt_reg + sbsf_pkg::CNT_ONE;
      end
      else if (!tx_push && tx_pop)
      begin
         tx_cnt_next = tx_cnt_reg - sbsf_pkg::CNT_ONE;
      end
      rx_cnt_next = rx_cnt_reg;
      if (rx_push && !rx_pop)
      begin
         rx_cnt_next = rx_cnt_reg + sbsf_pkg::CNT_ONE;
      end
      else if (!rx_push && rx_pop)
      begin
         rx_cnt_next = rx_cnt_reg - sbsf_pkg::CNT_ONE;
      end
      tx_wp_next = tx_push ? tx_wp_reg + sbsf_pkg::PTR_ONE : tx_wp_reg;
      tx_rp_next = tx_pop ? tx_rp_reg + sbsf_pkg::PTR_ONE : tx_rp_reg;
      rx_wp_next = rx_push ? rx_wp_reg + sbsf_pkg::PTR_ONE : rx_wp_reg;
      rx_rp_next = rx_pop ? rx_rp_reg + sbsf_pkg::PTR_ONE : rx_rp_reg;
      // Set on the filling write, clear once a location frees
      tx_full_next = (tx_cnt_next >= (enh_next ? sbsf_pkg::CAP_ENH
                                               : sbsf_pkg::CAP_STD));
      rx_full_next = (rx_cnt_next >= (enh_next ? sbsf_pkg::CAP_ENH
                                               : sbsf_pkg::CAP_STD));
      // Head word is valid one cycle after the read pointer settles
      tx_valid_next = (tx_cnt_next != sbsf_pkg::CNT_ZERO) && !tx_pop &&
                      !(tx_push && tx_cnt_reg == sbsf_pkg::CNT_ZERO);
      rx_stale_next = rx_push && rx_cnt_reg == sbsf_pkg::CNT_ZERO;
   end

   // Store ports
   assign tx_mem.we    = tx_push;
   assign tx_mem.waddr = tx_wp_reg;
   assign tx_mem.wdata = wr_word;
   assign tx_mem.raddr = tx_rp_next;
   assign rx_mem.we    = rx_push;
   assign rx_mem.waddr = rx_wp_reg;
   assign rx_mem.wdata = i_rx_word;
   assign rx_mem.raddr = rx_rp_reg;

   sbsf_mem u_tx_mem (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .port(tx_mem.store));
   sbsf_mem u_rx_mem (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .port(rx_mem.store));

   // ---------------------------------------------
   // Interrupts
   // ---------------------------------------------
   // Sticky bits, one-to-clear; a new event beats the clear
   always_comb
   begin
      irq_set = '0;
      irq_set[sbsf_pkg::IRQ_RX_DONE]  = rx_push;
      irq_set[sbsf_pkg::IRQ_TX_SPACE] = tx_full_reg && !tx_full_next;
      irq_set[sbsf_pkg::IRQ_RX_OVF]   = rx_drop;
      irq_set[sbsf_pkg::IRQ_TX_OVF]   = tx_refuse;
      irq_clr = '0;
      irq_mask_next = irq_mask_reg;
      if (wr_exec && w_strb_reg[0] && wr_off == sbsf_pkg::OFF_IRQ_STAT)
      begin
         irq_clr = w_data_reg[sbsf_pkg::IRQ_W-1:0];
      end
      if (wr_exec && w_strb_reg[0] && wr_off == sbsf_pkg::OFF_IRQ_MASK)
      begin
         irq_mask_next = w_data_reg[sbsf_pkg::IRQ_W-1:0];
      end
      irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
      irq_next      = |(irq_stat_next & irq_mask_next);
   end

   // ---------------------------------------------
   // Registers
   // ---------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         aw_hold_reg  <= 1'b0;
         aw_addr_reg  <= '0;
         w_hold_reg   <= 1'b0;
         w_data_reg   <= '0;
         w_strb_reg   <= '0;
         awready_reg  <= 1'b0;
         wready_reg   <= 1'b0;
         bvalid_reg   <= 1'b0;
         bresp_reg    <= sbsf_pkg::RESP_OKAY;
         rd_state_reg <= sbsf_pkg::RD_IDLE;
         ar_addr_reg  <= '0;
         arready_reg  <= 1'b0;
         rdata_reg    <= '0;
         rresp_reg    <= sbsf_pkg::RESP_OKAY;
         rvalid_reg   <= 1'b0;
         enh_reg      <= sbsf_pkg::ENH_RST;
         tx_cnt_reg   <= sbsf_pkg::CNT_ZERO;
         tx_wp_reg    <= '0;
         tx_rp_reg    <= '0;
         tx_full_reg  <= 1'b0;
         tx_valid_reg <= 1'b0;
         rx_cnt_reg   <= sbsf_pkg::CNT_ZERO;
         rx_wp_reg    <= '0;
         rx_rp_reg    <= '0;
         rx_full_reg  <= 1'b0;
         rx_stale_reg <= 1'b0;
         irq_stat_reg <= '0;
         irq_mask_reg <= sbsf_pkg::MASK_RST;
         irq_reg      <= 1'b0;
      end
      else
      begin
         aw_hold_reg  <= aw_hold_next;
         aw_addr_reg  <= aw_addr_next;
         w_hold_reg   <= w_hold_next;
         w_data_reg   <= w_data_next;
         w_strb_reg   <= w_strb_next;
         awready_reg  <= awready_next;
         wready_reg   <= wready_next;
         bvalid_reg   <= bvalid_next;
         bresp_reg    <= bresp_next;
         rd_state_reg <= rd_state_next;
         ar_addr_reg  <= ar_addr_next;
         arready_reg  <= arready_next;
         rdata_reg    <= rdata_next;
         rresp_reg    <= rresp_next;
         rvalid_reg   <= rvalid_next;
         enh_reg      <= enh_next;
         tx_cnt_reg   <= tx_cnt_next;
         tx_wp_reg    <= tx_wp_next;
         tx_rp_reg    <= tx_rp_next;
         tx_full_reg  <= tx_full_next;
         tx_valid_reg <= tx_valid_next;
         rx_cnt_reg   <= rx_cnt_next;
         rx_wp_reg    <= rx_wp_next;
         rx_rp_reg    <= rx_rp_next;
         rx_full_reg  <= rx_full_next;
         rx_stale_reg <= rx_stale_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         irq_reg      <= irq_next;
      end
   end

   // Outputs straight from flops
   assign o_awready             = awready_reg;
   assign o_wready              = wready_reg;
   assign o_bvalid              = bvalid_reg;
   assign o_bresp               = bresp_reg;
   assign o_arready             = arready_reg;
   assign o_rdata               = rdata_reg;
   assign o_rresp               = rresp_reg;
   assign o_rvalid              = rvalid_reg;
   assign o_tx_word             = tx_mem.rdata;
   assign o_tx_valid            = tx_valid_reg;
   assign o_tx_buffer_full_flag = tx_full_reg;
   assign o_rx_buffer_full_flag = rx_full_reg;
   assign o_irq                 = irq_reg;

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);

   a_tx_std_set: assert property (!enh_reg && !enh_next && tx_push |=> tx_full_reg)
      else $error("transmit full not set by write");
   a_tx_std_clr: assert property (!enh_reg && !enh_next && tx_pop |=> !tx_full_reg)
      else $error("transmit full not cleared by move");
   a_tx_enh_set: assert property ($rose(tx_full_reg) && $past(enh_reg) && enh_reg
      |-> $past(tx_push) && tx_cnt_reg == sbsf_pkg::CAP_ENH)
      else $error("transmit full set without last location");
   a_tx_enh_clr: assert property (enh_reg && enh_next && tx_full_reg && tx_pop
      |=> !tx_full_reg && tx_cnt_reg == sbsf_pkg::CAP_ENH - sbsf_pkg::CNT_ONE)
      else $error("transmit full kept with space");
   a_rx_std_set: assert property (!enh_reg && !enh_next && rx_push |=> rx_full_reg)
      else $error("receive full not set by move");
   a_rx_std_clr: assert property (!enh_reg && !enh_next && rx_pop && !rx_push
      |=> !rx_full_reg)
      else $error("receive full not cleared by read");
   a_rx_enh_set: assert property ($rose(rx_full_reg) && $past(enh_reg) && enh_reg
      |-> $past(rx_push) && rx_cnt_reg == sbsf_pkg::CAP_ENH)
      else $error("receive full set without last location");
   a_rx_enh_clr: assert property (enh_reg && enh_next && rx_full_reg && rx_pop
      && !rx_push |=> !rx_full_reg ##0 o_rvalid)
      else $error("receive full kept with space");
   a_mode_cap: assert property (tx_full_reg == (tx_cnt_reg >= cap) &&
      rx_full_reg == (rx_cnt_reg >= cap))
      else $error("flags disagree with mode capacity");
   a_read_lat: assert property (i_arvalid && o_arready |-> ##[2:3] o_rvalid)
      else $error("read answer late");
endmodule

/* design/sbsf_pkg.sv */
// ---------------------------------------------
// Shared constants of the buffer status block
// ---------------------------------------------
package sbsf_pkg;
   localparam int DATA_W = 32;   // Bus data width
   localparam int ADDR_W = 4;    // Bus address width
   localparam int WORD_W = 16;   // Serial word width
   localparam int DEPTH  = 8;    // Enhanced buffer depth
   localparam int PTR_W  = 3;    // Buffer pointer width
   localparam int CNT_W  = 4;    // Occupancy count width
   localparam int IRQ_W  = 4;    // Interrupt bits

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_BUF      = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_STAT     = 4'h4;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 4'h8;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'hC;

   // Status and control field positions
   localparam int STAT_RXF_BIT = 0;  // Receive full flag
   localparam int STAT_TXF_BIT = 1;  // Transmit full flag
   localparam int STAT_ENH_BIT = 2;  // Enhanced mode select

   // Interrupt field positions
   localparam int IRQ_RX_DONE  = 0;  // Word moved into receive buffer
   localparam int IRQ_TX_SPACE = 1;  // Transmit full flag dropped
   localparam int IRQ_RX_OVF   = 2;  // Word lost, receive side full
   localparam int IRQ_TX_OVF   = 3;  // Write refused, transmit full

   // Capacities per mode
   localparam logic [CNT_W-1:0] CAP_STD  = 4'h1;
   localparam logic [CNT_W-1:0] CAP_ENH  = 4'h8;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
   localparam logic [PTR_W-1:0] PTR_ONE  = 3'h1;

   // Reset values
   localparam logic             ENH_RST  = 1'h0;
   localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;

   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Read channel states
   typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_RESP} sbsf_rd_e;
endpackage

/* design/sbsf_mem_if.sv */
`timescale 1ns/1ps
// ---------------------------------------------
// Port of one word store
// ---------------------------------------------
interface sbsf_mem_if;
   logic                            we;     // Write strobe
   logic [sbsf_pkg::PTR_W-1:0]      waddr;  // Write location
   logic [sbsf_pkg::WORD_W-1:0]     wdata;  // Write word
   logic [sbsf_pkg::PTR_W-1:0]      raddr;  // Read location
   logic [sbsf_pkg::WORD_W-1:0]     rdata;  // Registered read word

   modport user  (output we, output waddr, output wdata, output raddr, input rdata);
   modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* design/sbsf_mem.sv */
`timescale 1ns/1ps
// ---------------------------------------------
// Word store with registered read
// ---------------------------------------------
module sbsf_mem
(
   input  wire logic    i_ref_clk,
   input  wire logic    i_nrst,
   sbsf_mem_if.store    port
);
   logic [sbsf_pkg::WORD_W-1:0] mem_q [sbsf_pkg::DEPTH];  // Storage, no reset
   logic [sbsf_pkg::WORD_W-1:0] rdata_reg;                 // Read register
   logic [sbsf_pkg::WORD_W-1:0] rdata_next;

   // Read sees the old word on a same-cycle write
   always_comb
   begin
      rdata_next = mem_q[port.raddr];
   end

   // Storage writes
   always_ff @(posedge i_ref_clk)
   begin
      if (port.we)
      begin
         mem_q[port.waddr] <= port.wdata;
      end
   end

   // Read register
   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rdata_reg <= '0;
      end
      else
      begin
         rdata_reg <= rdata_next;
      end
   end

   assign port.rdata = rdata_reg;
endmodule

/* tb/sbsf_shift_model.sv */
`timescale 1ns/1ps
// Shifter stand-in: takes transmit words, hands in receive words
module sbsf_shift_model
(
   input  wire logic                        i_ref_clk,
   input  wire logic                        i_take_en,
   input  wire logic                        i_tx_valid,
   input  wire logic                        i_load_req,
   input  wire logic [sbsf_pkg::WORD_W-1:0] i_load_word,
   output logic                             o_tx_take,
   output logic [sbsf_pkg::WORD_W-1:0]      o_rx_word,
   output logic                             o_rx_load
);
   initial
   begin
      o_tx_take = 1'h0;
      o_rx_load = 1'h0;
      o_rx_word = 16'h0;
   end
   // Take pulse with a gap, so one word moves per pulse
   always @(posedge i_ref_clk)
   begin
      o_tx_take <= i_take_en & i_tx_valid & ~o_tx_take;
      o_rx_load <= i_load_req;
      // Word is undefined outside a load: show the inverse
      o_rx_word <= i_load_req ? i_load_word : ~o_rx_word;
   end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   logic clk, nrst, awv, wv, bready, arv, rready, take_en, ld_req;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, seed, rd, first_w;
   logic [15:0] ldw, rxw, tx_got;
   wire awready, wready, bvalid, arready, rvalid, txv, take, rxld, txf, rxf, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [15:0] txw;
   int errors, cmp_count;
   sbsf_top dut (.i_ref_clk(clk), .i_nrst(nrst), .i_awaddr(awaddr), .i_awvalid(awv),
      .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wv),
      .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arv), .o_arready(arready), .o_rdata(rdata),
      .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .o_tx_word(txw),
      .o_tx_valid(txv), .i_tx_take(take), .i_rx_word(rxw), .i_rx_load(rxld),
      .o_tx_buffer_full_flag(txf), .o_rx_buffer_full_flag(rxf), .o_irq(irq));
   sbsf_shift_model sh (.i_ref_clk(clk), .i_take_en(take_en), .i_tx_valid(txv),
      .i_load_req(ld_req), .i_load_word(ldw), .o_tx_take(take), .o_rx_word(rxw),
      .o_rx_load(rxld));
   // Word handed to the shifter at each move
   always @(posedge clk)
   begin
      if (take && txv)
         tx_got <= txw;
   end
   // Seeded xorshift for repeatable data
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // Expected status word from mode and flags
   function automatic logic [31:0] st(input logic e, input logic t, input logic r);
      return {29'h0, e, t, r};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Bus write: both channels offered, each dropped once taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      bready <= 1'h1;
      do
      begin
         @(posedge clk);
         if (awready) awv <= 1'h0;
         if (wready) wv <= 1'h0;
      end while (!bvalid);
      bready <= 1'h0;
      chk(bresp, 32'h0);
   endtask
   task automatic rdr(input logic [3:0] a);
      @(posedge clk);
      araddr <= a;
      arv <= 1'h1;
      rready <= 1'h1;
      do
      begin
         @(posedge clk);
         if (arready) arv <= 1'h0;
      end while (!rvalid);
      rd = rdata;
      chk(rresp, 32'h0);
      rready <= 1'h0;
   endtask
   // Shifter delivers one word, then its effect settles
   task automatic load(input logic [15:0] w);
      @(posedge clk);
      ld_req <= 1'h1;
      ldw <= w;
      @(posedge clk);
      ld_req <= 1'h0;
      repeat (3) @(posedge clk);
   endtask
   // Bounded wait for the transmit flag to drop
   task automatic wt();
      for (int i = 0; i < 40 && txf !== 1'h0; i++) @(posedge clk);
   endtask
   initial
   begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      report_and_stop();
   end
   initial
   begin
      {nrst, awv, wv, bready, arv, rready, take_en, ld_req} = 8'h0;
      {awaddr, araddr, wdata, ldw} = 56'h0;
      wstrb = 4'hF;
      seed = 32'h612B;
      repeat (2) @(posedge clk);
      nrst <= 1'h1;
      repeat (2) @(posedge clk);
      rdr(4'h4);
      chk(rd, st(0, 0, 0));
      seed = xs(seed);
      wr(4'h0, seed);
      chk(txf, 1);
      take_en <= 1'h1;
      wt();
      chk(txf, 0);
      chk(tx_got, seed[15:0]);
      take_en <= 1'h0;
      wr(4'hC, 32'h1);
      load(seed[31:16]);
      chk(rxf, 1);
      chk(irq, 1);
      rdr(4'h0);
      chk(rd, {16'h0, seed[31:16]});
      chk(rxf, 0);
      wr(4'h8, 32'h1);
      repeat (2) @(posedge clk);
      chk(irq, 0);
      wr(4'h4, 32'h4);
      rdr(4'h4);
      chk(rd, st(1, 0, 0));
      for (int i = 0; i < 8; i++)
      begin
         seed = xs(seed);
         if (i == 0) first_w = seed;
         wr(4'h0, seed);
         chk(txf, i == 7);
         load(seed[31:16]);
         chk(rxf, i == 7);
      end
      // Both sides full: write refused, shifter word lost
      wr(4'h0, ~seed);
      chk(txf, 1);
      load(~seed[15:0]);
      rdr(4'h8);
      chk(rd, 32'hF);
      rdr(4'h0);
      chk(rd, {16'h0, first_w[31:16]});
      chk(rxf, 0);
      take_en <= 1'h1;
      wt();
      chk(txf, 0);
      chk(tx_got, first_w[15:0]);
      report_and_stop();
   end
endmodule
